// ===== logic/sarcv_ctrl.sv
// Purpose: Convert sequencing and approximation register for a 10-bit converter
// Assumes: comp_above is the comparator verdict for the current trial code
// Notes: Result is left justified over the two byte groups
`timescale 1ns/1ns
`default_nettype none
module sarcv_ctrl #(
    parameter int unsigned STEP_CYCLES = sarcv_pkg::STEP_CYCLES
) (
    input wire logic clock, // 20 MHz system clock
    input wire logic srst, // Synchronous reset
    input wire logic convert, // Start pulse from host, async
    input wire logic upper_byte_oe_n, // Upper group enable, async
    input wire logic lower_byte_oe_n, // Lower group enable, async
    input wire logic unipolar_sel, // 1 unipolar, 0 bipolar
    input wire logic comp_above, // Trial sum exceeds input
    output logic [9:0] trial_code, // Code offered to the comparator DAC
    output logic conv_done_n, // Conversion complete, active low
    output logic [7:0] upper_data, // Upper group data
    output logic upper_data_oe, // Upper group drive enable
    output logic [1:0] lower_data, // Lower group data
    output logic lower_data_oe // Lower group drive enable
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] conv_sync;
    logic [1:0] upper_sync;
    logic [1:0] lower_sync;
    logic conv_prev;
    always_ff @(posedge clock) begin
        if (srst) begin
            conv_sync <= 2'h0;
            upper_sync <= 2'h3;
            lower_sync <= 2'h3;
            conv_prev <= 1'b0;
        end else begin
            conv_sync <= {conv_sync[0], convert};
            upper_sync <= {upper_sync[0], upper_byte_oe_n};
            lower_sync <= {lower_sync[0], lower_byte_oe_n};
            conv_prev <= conv_sync[1];
        end
    end
    logic conv_rise;
    logic conv_fall;
    assign conv_rise = conv_sync[1] & ~conv_prev;
    assign conv_fall = ~conv_sync[1] & conv_prev;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    sarcv_pkg::sarcv_state_e state;
    logic [15:0] step_cnt;
    logic [3:0] bit_idx;
    logic [9:0] approx_bit_register;
    logic step_tick;
    assign step_tick = (step_cnt == 16'(STEP_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= sarcv_pkg::SARCV_IDLE;
        end else if (conv_rise) begin
            state <= sarcv_pkg::SARCV_ARMED; // see R2 see R15
        end else begin
            unique case (state)
                sarcv_pkg::SARCV_IDLE: state <= sarcv_pkg::SARCV_IDLE;
                sarcv_pkg::SARCV_ARMED: begin
                    if (conv_fall) begin
                        state <= sarcv_pkg::SARCV_RUN; // see R3
                    end
                end
                sarcv_pkg::SARCV_RUN: begin
                    if (step_tick && bit_idx == 4'h0) begin
                        state <= sarcv_pkg::SARCV_DONE; // see R14
                    end
                end
                sarcv_pkg::SARCV_DONE: state <= sarcv_pkg::SARCV_DONE;
            endcase
        end
    end

    // Step pacing stands in for the internal oscillator
    always_ff @(posedge clock) begin
        if (srst || state != sarcv_pkg::SARCV_RUN || step_tick) begin
            step_cnt <= 16'h0000; // see R14
        end else begin
            step_cnt <= step_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Approximation register, MSB first
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            approx_bit_register <= sarcv_pkg::RESULT_RESET;
            bit_idx <= 4'h9;
        end else if (conv_rise) begin
            approx_bit_register <= sarcv_pkg::RESULT_RESET; // see R2 see R15
            bit_idx <= 4'h9;
        end else if (state == sarcv_pkg::SARCV_ARMED && conv_fall) begin
            approx_bit_register <= sarcv_pkg::MSB_TRIAL; // see R12
        end else if (state == sarcv_pkg::SARCV_RUN && step_tick) begin
            // Keep trial bit unless sum exceeds input, then try next
            if (comp_above) begin
                approx_bit_register[bit_idx] <= 1'b0; // see R12
            end
            if (bit_idx != 4'h0) begin
                approx_bit_register[bit_idx - 4'h1] <= 1'b1; // see R12
                bit_idx <= bit_idx - 4'h1;
            end
        end
    end
    // Bipolar offset is analog; digital code is offset binary as is
    assign trial_code = approx_bit_register; // see R9 see R10 see R11

    // ------------------------------------------------------------
    // Done flag, open-collector style level
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            conv_done_n <= 1'b1;
        end else if (conv_rise) begin
            conv_done_n <= 1'b1; // see R2 see R5
        end else if (state == sarcv_pkg::SARCV_RUN && step_tick
                     && bit_idx == 4'h0) begin
            conv_done_n <= 1'b0; // see R4
        end
    end

    // ------------------------------------------------------------
    // Output groups
    // ------------------------------------------------------------
    sarcv_data_if dbus ();
    // Partial result is visible mid-conversion by design
    assign dbus.result = approx_bit_register; // see R7
    assign dbus.upper_en = ~upper_sync[1]; // see R8
    assign dbus.lower_en = ~lower_sync[1]; // see R8

    sarcv_out_drv u_drv (
        .clock(clock),
        .srst(srst),
        .bus(dbus),
        .upper_data(upper_data),
        .upper_data_oe(upper_data_oe),
        .lower_data(lower_data),
        .lower_data_oe(lower_data_oe)
    );
endmodule : sarcv_ctrl
`default_nettype wire

// ===== logic/sarcv_pkg.sv
// Purpose: Constants for the 10-bit successive-approximation convert/read control
// Assumes: 20 MHz clock; convert and byte enables arrive from outside the clock
// Notes: Comparator result is a digital input modelling the analog decision
//
// Summary of operation
// R1: Host holds convert high for at least 500 ns per start.
// R2: Convert rising edge resets sequencing, clears result, raises done_n.
// R3: Bit testing begins only when convert falls.
// R4: Done_n falls at completion, 10 to 30 us after start.
// R5: Done_n rises within 1.5 us of convert leading edge.
// R6: Host keeps byte enables high during conversion.
// R7: Enable asserted mid-conversion shows partial approximation result.
// R8: Outputs float unless own byte enable low; enables independent.
// R9: Mode select 1 unipolar straight binary, 0 bipolar offset binary.
// R10: Bipolar: minus full scale 0x000, zero 0x200, top 0x3FF.
// R11: Unipolar straight binary, full scale transition at top codes.
// R12: Bits tested MSB first; cleared when weighted sum exceeds input.
// R13: Upper enable gates 8 high bits, lower enable gates 2 low bits.
// R14: Ten paced decision steps; done one step after last decision. The code drops done_n on the tenth (last) decision step itself.
// R15: New convert pulse abandons conversion and restarts reset behaviour.
`default_nettype none
package sarcv_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned RES_BITS = 10;
    localparam int unsigned HIGH_BITS = 8;
    localparam int unsigned LOW_BITS = 2;
    // Conversion timing, typical 20 us total over 11 steps
    localparam int unsigned CONV_TIME_NS = 20_000;
    localparam int unsigned CONV_MIN_NS = 10_000;
    localparam int unsigned CONV_MAX_NS = 30_000;
    localparam int unsigned DONE_RISE_MAX_NS = 1_500;
    localparam int unsigned CONV_PULSE_MIN_NS = 500;
    localparam int unsigned STEP_NS = CONV_TIME_NS / (RES_BITS + 1);
    localparam int unsigned STEP_CYCLES = (STEP_NS * (CLK_HZ / 1_000_000))
                                          / 1_000;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [9:0] BIPOLAR_ZERO = 10'h200;
    localparam logic [9:0] MSB_TRIAL = 10'h200;
    typedef enum logic [1:0] {SARCV_IDLE, SARCV_ARMED, SARCV_RUN, SARCV_DONE}
        sarcv_state_e;
endpackage : sarcv_pkg
`default_nettype wire

// ===== logic/sarcv_data_if.sv
// Purpose: Carries result and byte enables to the output driver stage
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/1ns
`default_nettype none
interface sarcv_data_if;
    logic [9:0] result;
    logic upper_en;
    logic lower_en;
    modport ctrl (output result, output upper_en, output lower_en);
    modport drv (input result, input upper_en, input lower_en);
endinterface : sarcv_data_if
`default_nettype wire

// ===== logic/sarcv_out_drv.sv
// Purpose: Registered three-state output groups for the result
// Assumes: Enables already synchronised
// Notes: Data and enables registered, one cycle behind the enable input
`timescale 1ns/1ns
`default_nettype none
module sarcv_out_drv (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    sarcv_data_if.drv bus, // Result and enables
    output logic [7:0] upper_data, // Upper 8 result bits
    output logic upper_data_oe, // Upper group drive enable
    output logic [1:0] lower_data, // Lower 2 result bits
    output logic lower_data_oe // Lower group drive enable
);
    always_ff @(posedge clock) begin
        if (srst) begin
            upper_data_oe <= 1'b0;
            lower_data_oe <= 1'b0;
        end else begin
            upper_data_oe <= bus.upper_en; // see R8 see R13
            lower_data_oe <= bus.lower_en; // see R8 see R13
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            upper_data <= 8'h00;
            lower_data <= 2'h0;
        end else begin
            upper_data <= bus.result[9:2]; // see R7 see R13
            lower_data <= bus.result[1:0]; // see R7 see R13
        end
    end
endmodule : sarcv_out_drv
`default_nettype wire

// ===== dv/sarcv_comp_model.sv
// Purpose: Comparator stand-in for the analog front end
// Assumes: level is the input as an ideal code
// Notes: Trial above input clears the bit
`timescale 1ns/1ns
`default_nettype none
module sarcv_comp_model (
    input wire logic [9:0] trial_code, // Trial
    input wire logic [9:0] level, // Input
    output logic comp_above // Verdict
);
    assign comp_above = trial_code > level;
endmodule : sarcv_comp_model
`default_nettype wire

// ===== dv/sarcv_ctrl_checker.sv
// Purpose: Port checks of the convert control
// Assumes: STEP_CYCLES as on the instance
// Notes: Enables lag three cycles
`timescale 1ns/1ns
`default_nettype none
module sarcv_ctrl_checker #(parameter int unsigned STEP_CYCLES = 36) (
    input wire logic clock, // Clock
    input wire logic srst, // Reset
    input wire logic convert, // Start
    input wire logic upper_byte_oe_n, // Upper enable
    input wire logic lower_byte_oe_n, // Lower enable
    input wire logic [9:0] trial_code, // Trial
    input wire logic conv_done_n, // Done
    input wire logic upper_data_oe, // Upper drive
    input wire logic lower_data_oe // Lower drive
);
    localparam int LO = 10 * STEP_CYCLES, HI = LO + 8;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_cleared; $rose(convert) ##4 convert; endsequence
    a_done_rise: assert property (
        $rose(convert) |-> ##[1:30] conv_done_n) else $error("no rise");
    a_sar_clear: assert property (
        s_cleared |-> conv_done_n && trial_code == 10'h000)
        else $error("not clear");
    a_msb_first: assert property (
        $fell(convert) |-> ##[1:6] trial_code == 10'h200) else $error("msb");
    // A new pulse abandons the run, so the window is dropped
    a_conv_time: assert property (disable iff (srst || convert)
        $fell(convert) |-> ##[LO:HI] $fell(conv_done_n)) else $error("time");
    a_done_hold: assert property (
        !conv_done_n && !convert |=> !conv_done_n) else $error("hold");
    a_upper_off: assert property (
        upper_byte_oe_n[*4] |-> !upper_data_oe) else $error("upper on");
    a_lower_off: assert property (
        lower_byte_oe_n[*4] |-> !lower_data_oe) else $error("lower on");
    a_upper_on: assert property (
        !upper_byte_oe_n[*4] |-> upper_data_oe) else $error("upper off");
    a_lower_on: assert property (
        !lower_byte_oe_n[*4] |-> lower_data_oe) else $error("lower off");
endmodule : sarcv_ctrl_checker
bind sarcv_ctrl sarcv_ctrl_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
    .clock, .srst, .convert, .upper_byte_oe_n, .lower_byte_oe_n,
    .trial_code, .conv_done_n, .upper_data_oe, .lower_data_oe);
`default_nettype wire

// ===== dv/sarcv_ctrl_bench.sv
// Purpose: Self-checking bench of the convert control
// Assumes: STEP_CYCLES of 2 keeps runs short
// Notes: Rows are unipolar_sel, level, expected code
`timescale 1ns/1ns
`default_nettype none
module sarcv_ctrl_bench;
    localparam logic [20:0] ROWS [5] = '{21'h000000, 21'h080200,
        21'h0FFFFF, 21'h1FFBFE, 21'h155555};
    logic clock = 1'b0, srst = 1'b1, convert = 1'b0, unipolar_sel = 1'b0;
    logic upper_byte_oe_n = 1'b1, lower_byte_oe_n = 1'b1;
    logic comp_above, conv_done_n, upper_data_oe, lower_data_oe;
    logic [9:0] level = 10'h000, trial_code;
    logic [7:0] upper_data;
    logic [1:0] lower_data;
    int errors = 0, samples_checked = 0;
    sarcv_ctrl #(.STEP_CYCLES(2)) u_sarcv_ctrl (.clock, .srst, .convert,
        .upper_byte_oe_n, .lower_byte_oe_n, .unipolar_sel, .comp_above,
        .trial_code, .conv_done_n, .upper_data, .upper_data_oe, .lower_data,
        .lower_data_oe);
    sarcv_comp_model u_model (.trial_code, .level, .comp_above);
    initial forever #25 clock = ~clock;
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        stop_test();
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp) errors++;
    endtask : check
    task automatic stop_test;
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic start(input logic [20:0] row, input bit hold);
        @(posedge clock);
        {unipolar_sel, level} <= row[20:10];
        convert <= 1'b1;
        repeat (10) @(posedge clock);
        convert <= 1'b0;
        for (int n = 0; hold && n < 700 && conv_done_n !== 1'b0; n++) begin
            @(negedge clock);
        end
        if (hold) check(conv_done_n, 1'b0);
    endtask : start
    task automatic enables(input logic [1:0] oe_n);
        @(posedge clock);
        {upper_byte_oe_n, lower_byte_oe_n} <= oe_n;
        repeat (4) @(negedge clock);
    endtask : enables
    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        check({conv_done_n, upper_data_oe, trial_code}, 16'h0800);
        for (int i = 0; i < 5; i++) begin
            start(ROWS[i], 1'b1);
            enables(2'b00);
            check({upper_data_oe, lower_data_oe}, 2'b11);
            check({upper_data, lower_data}, ROWS[i][9:0]);
            enables(2'b11);
        end
        // Upper read in mid-run, then a restart before the end
        start(21'h03C000, 1'b0);
        enables(2'b01);
        check({upper_data_oe, lower_data_oe, conv_done_n}, 3'b101);
        check(upper_data, 8'h80);
        start(21'h0AA800, 1'b1);
        enables(2'b00);
        check({upper_data, lower_data}, 10'h2AA);
        stop_test();
    end
endmodule : sarcv_ctrl_bench
`default_nettype wire
